// ---- cyd_pkg.sv ----
package cyd_pkg;

  // opcode bytes
  localparam logic [7:0] OPC_PREFIX_Y  = 8'h18;
  localparam logic [7:0] OPC_PREFIX_XY = 8'h1a;
  localparam logic [7:0] OPC_CMPY_IMM  = 8'h8c;
  localparam logic [7:0] OPC_CMPY_DIR  = 8'h9c;
  localparam logic [7:0] OPC_CMPY_EXT  = 8'hbc;
  localparam logic [7:0] OPC_CMPY_IDX  = 8'hac;
  localparam logic [7:0] OPC_DECADJ    = 8'h19;

  // decimal correction values
  localparam logic [7:0] DA_NONE = 8'h00;
  localparam logic [7:0] DA_LO   = 8'h06;
  localparam logic [7:0] DA_HI   = 8'h60;
  localparam logic [7:0] DA_BOTH = 8'h66;

  // idle bus address closing a compare
  localparam logic [15:0] IDLE_ADDR = 16'hffff;

  // cycle counts per compare mode
  localparam logic [2:0] CYC_IMM = 3'h5;
  localparam logic [2:0] CYC_DIR = 3'h6;
  localparam logic [2:0] CYC_EXT = 3'h7;

  // condition code bit positions: s x h i n z v c
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_H = 5;

  localparam logic [7:0] CCR_RST = 8'hd0;

  typedef enum logic [1:0] {
    CYD_ST_IDLE = 2'b00,
    CYD_ST_HI   = 2'b01,
    CYD_ST_LO   = 2'b10,
    CYD_ST_END  = 2'b11
  } cyd_state_t;

endpackage : cyd_pkg

// ---- cyd_core.sv ----
// Operation
// - compare-Y subtracts 16-bit memory word (high byte first) from Y
// - compare-Y discards difference; Y and memory stay unchanged
// - compare-Y changes only N, Z, V, C flags
// - N is difference bit 15; Z set when difference is zero
// - V set on two's complement overflow of the subtraction
// - C set as borrow: unsigned memory word above Y
// - decode 18 8C/9C/BC/AC and 1A AC as compare-Y
// - decimal adjust adds correction from C, H and both nibbles to A
// - add 06 for low-nibble-only cases, carry stays clear
// - add 60 for high-nibble-only cases
// - add 66 when both nibbles need correction
// - carry set after 60 or 66, cleared after 00 or 06
// - valid BCD nibbles with C and H clear get 00
module cyd_core
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // decoder side
  input  wire logic        START,
  input  wire logic [7:0]  PAGE_BYTE,
  input  wire logic [7:0]  OP_BYTE,
  input  wire logic [15:0] EA,
  // operand fetch side
  input  wire logic [7:0]  RD_DATA,
  // architectural state in
  input  wire logic [15:0] Y_INDEX_REG,
  input  wire logic [7:0]  ACCUMULATOR_A,
  input  wire logic [7:0]  CONDITION_CODE_REG,
  // bus request out
  output logic [15:0]      BUS_ADDR,
  output logic             BUS_RD,
  // results out
  output logic [7:0]       ACC_A_OUT,
  output logic             ACC_A_WE,
  output logic [7:0]       CCR_OUT,
  output logic             CCR_WE,
  output logic             BUSY,
  output logic             ILLEGAL
);

  typedef struct packed {
    cyd_pkg::cyd_state_t st;
    logic [15:0]         addr;
    logic                rd;
    logic [7:0]          hi;
    logic [7:0]          acc;
    logic                acc_we;
    logic [7:0]          condition_code_reg;
    logic                ccr_we;
    logic                busy;
    logic                ill;
    logic [2:0]          ncyc;
    logic [2:0]          cyc;
  } cyd_regs_t;

  cyd_regs_t r_ff;
  cyd_regs_t nxt_r;

  logic        is_cmp;
  logic [2:0]  cmp_len;
  logic [16:0] diff;
  logic [7:0]  da_corr;
  logic [3:0]  up_n;
  logic [3:0]  lo_n;
  logic        c_in;
  logic        h_in;

  // instruction recognition and per-mode length
  always_comb
  begin
    is_cmp  = 1'b0;
    cmp_len = cyd_pkg::CYC_EXT;
    if (PAGE_BYTE == cyd_pkg::OPC_PREFIX_Y)
    begin
      unique case (OP_BYTE)
        cyd_pkg::OPC_CMPY_IMM:
        begin
          is_cmp  = 1'b1;
          cmp_len = cyd_pkg::CYC_IMM;
        end
        cyd_pkg::OPC_CMPY_DIR:
        begin
          is_cmp  = 1'b1;
          cmp_len = cyd_pkg::CYC_DIR;
        end
        cyd_pkg::OPC_CMPY_EXT,
        cyd_pkg::OPC_CMPY_IDX:
          is_cmp = 1'b1;
        default:
          is_cmp = 1'b0;
      endcase
    end
    else if (PAGE_BYTE == cyd_pkg::OPC_PREFIX_XY &&
             OP_BYTE == cyd_pkg::OPC_CMPY_IDX)
      is_cmp = 1'b1;
  end

  // decimal correction table; unlisted combos fall to nearest row
  always_comb
  begin
    up_n = ACCUMULATOR_A[7:4];
    lo_n = ACCUMULATOR_A[3:0];
    c_in = CONDITION_CODE_REG[cyd_pkg::CC_C];
    h_in = CONDITION_CODE_REG[cyd_pkg::CC_H];
    da_corr = cyd_pkg::DA_NONE;
    if (!c_in)
    begin
      if (!h_in && lo_n > 4'h9)
        da_corr = (up_n > 4'h8) ? cyd_pkg::DA_BOTH : cyd_pkg::DA_LO;
      else if (h_in && lo_n < 4'h4)
        da_corr = (up_n > 4'h9) ? cyd_pkg::DA_BOTH : cyd_pkg::DA_LO;
      else if (!h_in && up_n > 4'h9)
        da_corr = cyd_pkg::DA_HI;
    end
    else
    begin
      if ((!h_in && lo_n > 4'h9) || h_in)
        da_corr = cyd_pkg::DA_BOTH;
      else
        da_corr = cyd_pkg::DA_HI;
    end
  end

  // 17-bit subtract exposes the borrow in the top bit
  assign diff = {1'b0, Y_INDEX_REG} - {1'b0, r_ff.hi, RD_DATA};

  // sequencer: one state record, filled here, registered below
  always_comb
  begin
    nxt_r        = r_ff;
    nxt_r.acc_we = 1'b0;
    nxt_r.ccr_we = 1'b0;
    nxt_r.ill    = 1'b0;
    nxt_r.rd     = 1'b0;
    nxt_r.cyc    = r_ff.cyc + 3'h1;
    unique case (r_ff.st)
      cyd_pkg::CYD_ST_IDLE:
      begin
        nxt_r.busy = 1'b0;
        if (START && is_cmp)
        begin
          // the two fetch cycles land just before the idle read
          nxt_r.st   = cyd_pkg::CYD_ST_HI;
          nxt_r.busy = 1'b1;
          nxt_r.ncyc = cmp_len;
          nxt_r.cyc  = 3'h1;
          nxt_r.addr = EA;
          nxt_r.rd   = 1'b1;
        end
        else if (START && PAGE_BYTE == cyd_pkg::OPC_DECADJ)
        begin
          // only A and carry are written back
          nxt_r.acc    = ACCUMULATOR_A + da_corr;
          nxt_r.acc_we = 1'b1;
          nxt_r.condition_code_reg    = CONDITION_CODE_REG;
          nxt_r.condition_code_reg[cyd_pkg::CC_C] = da_corr[6];
          nxt_r.ccr_we = 1'b1;
        end
        else if (START)
          nxt_r.ill = 1'b1;
      end
      cyd_pkg::CYD_ST_HI:
      begin
        nxt_r.addr = r_ff.addr + 16'h0001;
        nxt_r.rd   = 1'b1;
        nxt_r.st   = cyd_pkg::CYD_ST_LO;
      end
      cyd_pkg::CYD_ST_LO:
      begin
        // memory is registered: high byte answers last cycle's address
        nxt_r.hi   = RD_DATA;
        nxt_r.addr = cyd_pkg::IDLE_ADDR;
        nxt_r.rd   = 1'b1;
        nxt_r.st   = cyd_pkg::CYD_ST_END;
      end
      cyd_pkg::CYD_ST_END:
      begin
        // low byte on the bus now; result discarded, Y never written
        nxt_r.condition_code_reg = CONDITION_CODE_REG;
        nxt_r.condition_code_reg[cyd_pkg::CC_N] = diff[15];
        nxt_r.condition_code_reg[cyd_pkg::CC_Z] = (diff[15:0] == 16'h0000);
        nxt_r.condition_code_reg[cyd_pkg::CC_V] =
          (Y_INDEX_REG[15] ^ r_ff.hi[7]) &
          (diff[15] ^ Y_INDEX_REG[15]);
        nxt_r.condition_code_reg[cyd_pkg::CC_C] = diff[16];
        nxt_r.ccr_we = 1'b1;
        nxt_r.st     = cyd_pkg::CYD_ST_IDLE;
        nxt_r.busy   = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      r_ff     <= '0;
      r_ff.st  <= cyd_pkg::CYD_ST_IDLE;
      r_ff.condition_code_reg <= cyd_pkg::CCR_RST;
    end
    else
      r_ff <= nxt_r;
  end

  assign BUS_ADDR  = r_ff.addr;
  assign BUS_RD    = r_ff.rd;
  assign ACC_A_OUT = r_ff.acc;
  assign ACC_A_WE  = r_ff.acc_we;
  assign CCR_OUT   = r_ff.condition_code_reg;
  assign CCR_WE    = r_ff.ccr_we;
  assign BUSY      = r_ff.busy;
  assign ILLEGAL   = r_ff.ill;

  // checks
  property p_idle_after_lo;
    @(posedge CLK) disable iff (SYS_RST)
    (r_ff.st == cyd_pkg::CYD_ST_LO) |=>
      ((BUS_ADDR == cyd_pkg::IDLE_ADDR) && BUS_RD) ##1 CCR_WE;
  endproperty
  a_idle_after_lo: assert property (p_idle_after_lo)
    else $error("idle read missing after compare");

  property p_cmp_keeps_sxhi;
    @(posedge CLK) disable iff (SYS_RST)
    (r_ff.st == cyd_pkg::CYD_ST_END) |=>
      CCR_OUT[7:4] == $past(CONDITION_CODE_REG[7:4]);
  endproperty
  a_cmp_keeps_sxhi: assert property (p_cmp_keeps_sxhi)
    else $error("compare altered upper flags");

  property p_z_flag;
    @(posedge CLK) disable iff (SYS_RST)
    (r_ff.st == cyd_pkg::CYD_ST_END) |=>
      CCR_OUT[cyd_pkg::CC_Z] ==
      ($past(Y_INDEX_REG) == {$past(r_ff.hi), $past(RD_DATA)});
  endproperty
  a_z_flag: assert property (p_z_flag)
    else $error("zero flag wrong");

  property p_c_flag;
    @(posedge CLK) disable iff (SYS_RST)
    (r_ff.st == cyd_pkg::CYD_ST_END) |=>
      CCR_OUT[cyd_pkg::CC_C] ==
      ($past(Y_INDEX_REG) < {$past(r_ff.hi), $past(RD_DATA)});
  endproperty
  a_c_flag: assert property (p_c_flag)
    else $error("borrow flag wrong");

  sequence s_fetch;
    (r_ff.st == cyd_pkg::CYD_ST_HI) ##1 (r_ff.st == cyd_pkg::CYD_ST_LO);
  endsequence
  property p_ascending;
    @(posedge CLK) disable iff (SYS_RST)
    s_fetch |-> BUS_ADDR == $past(BUS_ADDR) + 16'h0001;
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("operand bytes not ascending");

  property p_da_carry;
    @(posedge CLK) disable iff (SYS_RST)
    ACC_A_WE |-> CCR_OUT[cyd_pkg::CC_C] ==
      (((ACC_A_OUT - $past(ACCUMULATOR_A)) & 8'hf0) == 8'h60);
  endproperty
  a_da_carry: assert property (p_da_carry)
    else $error("decimal adjust carry wrong");

  property p_da_valid;
    @(posedge CLK) disable iff (SYS_RST)
    (START && r_ff.st == cyd_pkg::CYD_ST_IDLE &&
     PAGE_BYTE == cyd_pkg::OPC_DECADJ && ACCUMULATOR_A == 8'h45 &&
     CONDITION_CODE_REG[1:0] == 2'h0 && !CONDITION_CODE_REG[5])
    |=> ACC_A_OUT == 8'h45 && !CCR_OUT[cyd_pkg::CC_C];
  endproperty
  a_da_valid: assert property (p_da_valid)
    else $error("valid bcd altered");

  property p_da_both;
    @(posedge CLK) disable iff (SYS_RST)
    (START && r_ff.st == cyd_pkg::CYD_ST_IDLE &&
     PAGE_BYTE == cyd_pkg::OPC_DECADJ && ACCUMULATOR_A == 8'hbb &&
     !CONDITION_CODE_REG[0] && !CONDITION_CODE_REG[5])
    |=> ACC_A_OUT == 8'h21 && CCR_OUT[cyd_pkg::CC_C] && ACC_A_WE;
  endproperty
  a_da_both: assert property (p_da_both)
    else $error("double correction wrong");

  property p_da_keeps;
    @(posedge CLK) disable iff (SYS_RST)
    ACC_A_WE |-> CCR_OUT[7:1] == $past(CONDITION_CODE_REG[7:1]);
  endproperty
  a_da_keeps: assert property (p_da_keeps)
    else $error("decimal adjust altered other flags");

endmodule : cyd_core

// ---- compare_y_and_decimal_adjust_bench.sv ----
module compare_y_and_decimal_adjust_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, SYS_RST, START, BUS_RD, ACC_A_WE, CCR_WE, BUSY, ILLEGAL;
  logic [7:0]  PAGE_BYTE, OP_BYTE, ACCUMULATOR_A, CONDITION_CODE_REG;
  logic [7:0]  ACC_A_OUT, CCR_OUT;
  logic [7:0]  RD_DATA = 8'h00;
  logic [15:0] EA, Y_INDEX_REG, BUS_ADDR, mem_word, addr_q;
  logic [15:0] rd_log [4];
  int          fails, total_checks, rd_n, a_we_n, k;
  // decimal cases: c h cout 0 | a | result
  logic [19:0] da_tab [11] = '{20'h04545, 20'h08b91, 20'h49298, 20'h2a505,
    20'h2bb21, 20'h6f157, 20'ha2585, 20'ha0c72, 20'he3197, 20'h29a00,
    20'h09999};

  cyd_core i_cyd_core (.CLK(CLK), .SYS_RST(SYS_RST), .START(START),
    .PAGE_BYTE(PAGE_BYTE), .OP_BYTE(OP_BYTE), .EA(EA), .RD_DATA(RD_DATA),
    .Y_INDEX_REG(Y_INDEX_REG), .ACCUMULATOR_A(ACCUMULATOR_A),
    .CONDITION_CODE_REG(CONDITION_CODE_REG), .BUS_ADDR(BUS_ADDR),
    .BUS_RD(BUS_RD), .ACC_A_OUT(ACC_A_OUT), .ACC_A_WE(ACC_A_WE),
    .CCR_OUT(CCR_OUT), .CCR_WE(CCR_WE), .BUSY(BUSY), .ILLEGAL(ILLEGAL));

  // 125 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // memory answers one cycle late; unused addresses give a changing pattern
  always @(posedge CLK) addr_q <= BUS_ADDR;
  always @(negedge CLK)
    RD_DATA <= (addr_q == EA) ? mem_word[15:8] :
               (addr_q == EA + 16'h1) ? mem_word[7:0] : ~addr_q[7:0];

  // log operand reads and stray accumulator writes
  always @(posedge CLK)
  begin
    if (BUS_RD === 1'b1 && BUS_ADDR !== 16'hffff && rd_n < 4)
      rd_log[rd_n] <= BUS_ADDR;
    rd_n += (BUS_RD === 1'b1 && BUS_ADDR !== 16'hffff);
    a_we_n += (ACC_A_WE === 1'b1);
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // held n cycles: later edges fall while busy and must be ignored
  task go(input logic [7:0] pg, input logic [7:0] op, input int n);
    @(negedge CLK);
    PAGE_BYTE = pg;
    OP_BYTE = op;
    START = 1'b1;
    repeat (n) @(negedge CLK);
    START = 1'b0;
  endtask : go

  task wait_ccr;
    for (k = 0; k < 6 && CCR_WE !== 1'b1; k++) @(negedge CLK);
  endtask : wait_ccr

  task t_da(input logic [19:0] r);
    @(negedge CLK);
    ACCUMULATOR_A = r[15:8];
    CONDITION_CODE_REG = {2'b11, r[18], 4'h0, r[19]};
    go(8'h19, 8'h00, 1);
    wait_ccr;
    chk(ACC_A_WE, 1'b1);
    chk(ACC_A_OUT, r[7:0]);
    chk(CCR_OUT[0], r[17]);
    chk(CCR_OUT[3:2], 2'h0);
    $display("decimal adjust of %h done", r[15:8]);
  endtask : t_da

  task t_cmp(input logic [7:0] pg, input logic [7:0] op,
             input logic [15:0] ea, input logic [15:0] y,
             input logic [15:0] m);
    logic [16:0] d;
    logic        v;
    d = {1'b0, y} - {1'b0, m};
    v = (y[15] ^ m[15]) & (d[15] ^ y[15]);
    @(negedge CLK);
    EA = ea;
    Y_INDEX_REG = y;
    mem_word = m;
    CONDITION_CODE_REG = 8'ha5;
    rd_n = 0;
    a_we_n = 0;
    go(pg, op, 2);
    wait_ccr;
    chk(CCR_WE, 1'b1);
    chk(CCR_OUT[7:4], 4'ha);
    chk(CCR_OUT[3:2], {d[15], d[15:0] == 16'h0});
    chk(CCR_OUT[1:0], {v, d[16]});
    chk(BUS_ADDR, 16'hffff);
    repeat (3) @(negedge CLK);
    chk(BUSY, 1'b0);
    chk(16'(rd_n), 16'h2);
    chk(rd_log[0], ea);
    chk(rd_log[1], ea + 16'h1);
    chk(16'(a_we_n), 16'h0);
    $display("compare %h %h done", pg, op);
  endtask : t_cmp

  task t_ill;
    go(8'h18, 8'h8b, 1);
    for (k = 0; k < 4 && ILLEGAL !== 1'b1; k++) @(negedge CLK);
    chk(ILLEGAL, 1'b1);
    chk(BUSY, 1'b0);
    $display("unknown opcode done");
  endtask : t_ill

  // watchdog: the whole run needs well under 5000 cycles
  initial
  begin
    #40000;
    fails++;
    end_of_test;
  end

  initial
  begin
    SYS_RST = 1'b1;
    START = 1'b0;
    PAGE_BYTE = 8'h00;
    OP_BYTE = 8'h00;
    EA = 16'h0;
    mem_word = 16'h0;
    Y_INDEX_REG = 16'h0;
    ACCUMULATOR_A = 8'h0;
    CONDITION_CODE_REG = 8'hd0;
    repeat (20) @(negedge CLK);
    chk(CCR_OUT, 8'hd0);
    chk(BUSY, 1'b0);
    SYS_RST = 1'b0;
    foreach (da_tab[i]) t_da(da_tab[i]);
    t_cmp(8'h18, 8'h8c, 16'h0100, 16'h1234, 16'h1200);
    t_cmp(8'h18, 8'h9c, 16'h0040, 16'h5555, 16'h5555);
    t_cmp(8'h18, 8'hbc, 16'h8000, 16'h0001, 16'h0002);
    t_cmp(8'h18, 8'hac, 16'h2000, 16'h8000, 16'h0001);
    t_cmp(8'h1a, 8'hac, 16'h30ff, 16'h7fff, 16'hffff);
    t_ill;
    end_of_test;
  end
endmodule : compare_y_and_decimal_adjust_bench
